// File: shared/deser_datapath_defines.vh
`ifndef DESER_DATAPATH_DEFINES_VH
`define DESER_DATAPATH_DEFINES_VH

// ****************************************
// Word indexes; byte address is index * 4
// ****************************************
`define IDX_DATAPATH_CFG 10'h022
`define IDX_RX_MODE 10'h023
`define IDX_IRQ_STATUS 10'h030
`define IDX_IRQ_MASK 10'h031
`define IDX_PROT_STATUS 10'h032

// ****************************************
// Datapath configuration fields
// ****************************************
`define CFG_LOCK_BIT 7
`define CFG_UNGATED_BIT 6
`define CFG_POLARITY_BIT 5
`define CFG_AUD_SUPPRESS_BIT 4
`define CFG_4CH_OVR_BIT 3
`define CFG_PIX18_BIT 2
`define CFG_INBAND_BIT 1
`define CFG_4CH_EN_BIT 0
`define CFG_RESET 8'h00

// ****************************************
// Receive mode fields
// ****************************************
`define RX_CHK_ON_BIT 7
`define RX_RESET 8'h00

// ****************************************
// Interrupt status and mask fields
// ****************************************
`define IRQ_CHK_FAIL_BIT 0
`define IRQ_FC_APPLIED_BIT 1
`define IRQ_FC_BLOCKED_BIT 2
`define IRQ_USED_MASK 8'h07
`define IRQ_RESET 8'h00

// ****************************************
// Protection status fields
// ****************************************
`define PROT_FAIL_BIT 0
`define PROT_CNT_LSB 4
`define PROT_CNT_MAX 4'hF
`define PROT_RESET 8'h00

// ****************************************
// Pixel layout
// ****************************************
`define PIX18_MASK 24'hFCFCFC

`endif

// File: rtl/line_checksum.v
`timescale 1ns/1ns
`include "deser_datapath_defines.vh"

module line_checksum (
   input wire hclk,
   input wire hresetn,
   input wire check_on,
   input wire line_active,
   input wire [23:0] pix_data,
   input wire chk_valid,
   input wire [7:0] chk_byte,
   output reg mismatch_r,
   output reg match_r
);

   // ****************************************
   // Running byte sum over the active line
   // ****************************************
   reg [7:0] acc_r;
   reg [7:0] acc_nxt;
   reg line_d_r;
   wire [7:0] pix_sum;

   assign pix_sum = pix_data[23:16] + pix_data[15:8] + pix_data[7:0];

   always @* begin
      acc_nxt = acc_r;
      if (line_active && !line_d_r) begin
         acc_nxt = pix_sum;
      end else if (line_active) begin
         acc_nxt = acc_r + pix_sum;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r <= 8'h00;
         line_d_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         line_d_r <= line_active;
      end
   end

   // ****************************************
   // Compare the byte that trails the line
   // ****************************************
   // A checksum byte seen while the line is still active is ignored
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mismatch_r <= 1'b0;
         match_r <= 1'b0;
      end else begin
         mismatch_r <= check_on && chk_valid && !line_active &&
            (chk_byte != acc_r);
         match_r <= check_on && chk_valid && !line_active &&
            (chk_byte == acc_r);
      end
   end

endmodule // line_checksum

// File: rtl/deser_datapath_config_regs.v
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "deser_datapath_defines.vh"

module deser_datapath_config_regs (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output reg [31:0] hrdata,
   output wire hresp,
   input wire fc_cfg_valid,
   input wire [6:0] fc_cfg_data,
   input wire line_active_strobe,
   input wire [23:0] pix_in,
   input wire aud_pkt_valid,
   input wire [23:0] aud_pkt_data,
   input wire chk_valid,
   input wire [7:0] chk_byte,
   output reg [23:0] pix_out_r,
   output reg pix_valid_r,
   output reg aud_on_pixel_pins_r,
   output wire protection_enable,
   output wire pixel_mode_18,
   output wire audio_inband_sel,
   output wire four_ch_audio_en,
   output wire irq
);

   // ****************************************
   // Declarations
   // ****************************************
   reg [7:0] cfg_r;
   reg [7:0] cfg_nxt;
   reg [7:0] rx_mode_r;
   reg [7:0] rx_mode_nxt;
   reg [7:0] irq_status_r;
   reg [7:0] irq_status_nxt;
   reg [7:0] irq_mask_r;
   reg [7:0] irq_mask_nxt;
   reg [7:0] prot_r;
   reg [7:0] prot_nxt;
   reg [3:0] fail_cnt;
   reg wr_pend_r;
   reg [9:0] wr_idx_r;
   reg rd_wait_r;
   reg [9:0] rd_idx_r;
   reg [7:0] rd_mux;
   wire accept;
   wire wr_commit;
   wire [7:0] wdata;
   wire wr_cfg;
   wire wr_rx;
   wire wr_stat;
   wire wr_mask;
   wire wr_prot;
   wire lock;
   wire ungated;
   wire polarity;
   wire aud_suppress;
   wire fc_apply;
   wire fc_blocked;
   wire line_active;
   wire chk_fail;
   wire chk_ok;
   wire [7:0] irq_set;
   wire [7:0] irq_clr;

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   // Writes finish with no wait state; reads take one wait state so
   // the read data come from a flop and see a write just before them.
   assign accept = hsel && hready && htrans[1];
   assign hreadyout = !rd_wait_r;
   assign hresp = 1'b0;
   assign wr_commit = wr_pend_r;
   assign wdata = hwdata[7:0];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 10'h000;
         rd_wait_r <= 1'b0;
         rd_idx_r <= 10'h000;
      end else begin
         wr_pend_r <= accept && hwrite;
         rd_wait_r <= accept && !hwrite;
         if (accept) begin
            wr_idx_r <= haddr[11:2];
            rd_idx_r <= haddr[11:2];
         end
      end
   end

   assign wr_cfg = wr_commit && (wr_idx_r == `IDX_DATAPATH_CFG);
   assign wr_rx = wr_commit && (wr_idx_r == `IDX_RX_MODE);
   assign wr_stat = wr_commit && (wr_idx_r == `IDX_IRQ_STATUS);
   assign wr_mask = wr_commit && (wr_idx_r == `IDX_IRQ_MASK);
   assign wr_prot = wr_commit && (wr_idx_r == `IDX_PROT_STATUS);

   // Unmapped words read as zero
   always @* begin
      case (rd_idx_r)
         `IDX_DATAPATH_CFG: rd_mux = cfg_r;
         `IDX_RX_MODE: rd_mux = rx_mode_r;
         `IDX_IRQ_STATUS: rd_mux = irq_status_r;
         `IDX_IRQ_MASK: rd_mux = irq_mask_r;
         `IDX_PROT_STATUS: rd_mux = prot_r;
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_wait_r) begin
         hrdata <= {24'h000000, rd_mux};
      end
   end

   // ****************************************
   // Datapath configuration register
   // ****************************************
   assign lock = cfg_r[`CFG_LOCK_BIT];
   assign fc_apply = fc_cfg_valid && !lock;
   assign fc_blocked = fc_cfg_valid && lock;

   // A software write in the same cycle wins over a remote update,
   // since software owns the lock bit and may be setting it right now.
   always @* begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = wdata;
      end else if (fc_apply) begin
         cfg_nxt = {cfg_r[`CFG_LOCK_BIT], fc_cfg_data};
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= `CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // ****************************************
   // Receive mode register
   // ****************************************
   // Only the checksum enable lives here; other bits read zero
   always @* begin
      rx_mode_nxt = rx_mode_r;
      if (wr_rx) begin
         rx_mode_nxt = 8'h00;
         rx_mode_nxt[`RX_CHK_ON_BIT] = wdata[`RX_CHK_ON_BIT];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_mode_r <= `RX_RESET;
      end else begin
         rx_mode_r <= rx_mode_nxt;
      end
   end

   // ****************************************
   // Decoded controls
   // ****************************************
   assign ungated = cfg_r[`CFG_UNGATED_BIT];
   assign polarity = cfg_r[`CFG_POLARITY_BIT];
   assign aud_suppress = cfg_r[`CFG_AUD_SUPPRESS_BIT];
   assign line_active = line_active_strobe ^ polarity;
   assign protection_enable = !ungated;
   assign pixel_mode_18 = cfg_r[`CFG_PIX18_BIT];
   assign audio_inband_sel = cfg_r[`CFG_INBAND_BIT];
   assign four_ch_audio_en = cfg_r[`CFG_4CH_OVR_BIT] ?
      cfg_r[`CFG_4CH_EN_BIT] : 1'b0;

   // ****************************************
   // Pixel output path
   // ****************************************
   // Audio packets share the pixel pins; they are put there only when
   // not suppressed and not in ungated mode, and then take the slot.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pix_out_r <= 24'h000000;
         pix_valid_r <= 1'b0;
         aud_on_pixel_pins_r <= 1'b0;
      end else begin
         aud_on_pixel_pins_r <= aud_pkt_valid && !aud_suppress &&
            !ungated;
         if (aud_pkt_valid && !aud_suppress && !ungated) begin
            pix_out_r <= aud_pkt_data;
            pix_valid_r <= 1'b0;
         end else begin
            pix_valid_r <= ungated || line_active;
            if (pixel_mode_18) begin
               pix_out_r <= pix_in & `PIX18_MASK;
            end else begin
               pix_out_r <= pix_in;
            end
         end
      end
   end

   // ****************************************
   // Line checksum
   // ****************************************
   line_checksum u_chk (
      .hclk(hclk),
      .hresetn(hresetn),
      .check_on(rx_mode_r[`RX_CHK_ON_BIT]),
      .line_active(line_active),
      .pix_data(pix_in),
      .chk_valid(chk_valid),
      .chk_byte(chk_byte),
      .mismatch_r(chk_fail),
      .match_r(chk_ok)
   );

   // ****************************************
   // Protection status register
   // ****************************************
   // Fail count saturates; writing one to the fail bit clears both,
   // but a mismatch in that same cycle still sets the flag again.
   always @* begin
      prot_nxt = prot_r;
      fail_cnt = prot_r[`PROT_CNT_LSB+3:`PROT_CNT_LSB];
      if (wr_prot && wdata[`PROT_FAIL_BIT]) begin
         prot_nxt[`PROT_FAIL_BIT] = 1'b0;
         fail_cnt = 4'h0;
      end
      if (chk_fail) begin
         prot_nxt[`PROT_FAIL_BIT] = 1'b1;
         if (fail_cnt != `PROT_CNT_MAX) begin
            fail_cnt = fail_cnt + 4'h1;
         end
      end
      prot_nxt[`PROT_CNT_LSB+3:`PROT_CNT_LSB] = fail_cnt;
      prot_nxt[3:1] = 3'b000;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prot_r <= `PROT_RESET;
      end else begin
         prot_r <= prot_nxt;
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   assign irq_set = {5'b00000, fc_blocked, fc_apply, chk_fail};
   assign irq_clr = wr_stat ? wdata : 8'h00;

   always @* begin
      irq_status_nxt = ((irq_status_r & ~irq_clr) | irq_set) &
         `IRQ_USED_MASK;
      irq_mask_nxt = irq_mask_r;
      if (wr_mask) begin
         irq_mask_nxt = wdata & `IRQ_USED_MASK;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_r <= `IRQ_RESET;
         irq_mask_r <= `IRQ_RESET;
      end else begin
         irq_status_r <= irq_status_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

   // Match pulse and transfer size are not used beyond this point
   wire unused_ok;
   assign unused_ok = chk_ok ^ (|hsize);

endmodule // deser_datapath_config_regs

// File: verif/fc_serializer_model.sv
`timescale 1ns/1ns
module fc_serializer_model (
   input wire hclk,
   output logic fc_cfg_valid,
   output logic [6:0] fc_cfg_data
);
   initial begin
      fc_cfg_valid = 1'b0;
      fc_cfg_data = 7'h55;
   end
   // Idle data is inverted so a stale value never looks valid
   task send(input logic [6:0] d, input int gap);
      begin
         repeat (gap) @(posedge hclk);
         fc_cfg_valid <= 1'b1;
         fc_cfg_data <= d;
         @(posedge hclk);
         fc_cfg_valid <= 1'b0;
         fc_cfg_data <= ~d;
      end
   endtask
endmodule // fc_serializer_model

// File: verif/deser_cfg_asserts.sv
`timescale 1ns/1ns
module deser_cfg_asserts (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire [31:0] hrdata,
   input wire hresp,
   input wire fc_cfg_valid,
   input wire [23:0] pix_in,
   input wire aud_pkt_valid,
   input wire [23:0] aud_pkt_data,
   input wire [23:0] pix_out_r,
   input wire pix_valid_r,
   input wire aud_on_pixel_pins_r,
   input wire protection_enable,
   input wire pixel_mode_18,
   input wire audio_inband_sel,
   input wire four_ch_audio_en
);
   reg wr_ph_r;
   reg armed_r;
   wire take = hsel && hready && htrans[1];
   wire [3:0] dec = {protection_enable, pixel_mode_18, audio_inband_sel,
      four_ch_audio_en};
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn || !armed_r);
   // Release edge still sees reset in the flops; skip attempts from it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) armed_r <= 1'b0;
      else armed_r <= 1'b1;
   end
   // Writes land one cycle after the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wr_ph_r <= 1'b0;
      else wr_ph_r <= take && hwrite;
   end
   // ********************
   // Properties
   // ********************
   sequence rd_take; take && !hwrite; endsequence
   sequence one_wait; !hreadyout ##1 hreadyout; endsequence
   chk_read_wait: assert property (rd_take |=> one_wait)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_rdata_high: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_cfg_hold: assert property (
      !fc_cfg_valid && !wr_ph_r |=> $stable(dec))
      else $error("config changed without update");
   chk_ungated_pass: assert property (
      !protection_enable |=> pix_valid_r && !aud_on_pixel_pins_r)
      else $error("ungated pixels not passed");
   chk_pix_narrow: assert property (
      pixel_mode_18 |=> aud_on_pixel_pins_r ||
      pix_out_r == ($past(pix_in) & 24'hFCFCFC))
      else $error("18-bit mask wrong");
   chk_pix_wide: assert property (
      !pixel_mode_18 |=> aud_on_pixel_pins_r || pix_out_r == $past(pix_in))
      else $error("24-bit pixel wrong");
   chk_audio_pins: assert property (
      aud_on_pixel_pins_r |-> $past(aud_pkt_valid && protection_enable)
      && !pix_valid_r && pix_out_r == $past(aud_pkt_data))
      else $error("audio on pins wrong");
endmodule // deser_cfg_asserts
bind deser_datapath_config_regs deser_cfg_asserts chk_u (.hclk, .hresetn,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
   .fc_cfg_valid, .pix_in, .aud_pkt_valid, .aud_pkt_data, .pix_out_r,
   .pix_valid_r, .aud_on_pixel_pins_r, .protection_enable, .pixel_mode_18,
   .audio_inband_sel, .four_ch_audio_en);

// File: verif/tb_top.sv
`timescale 1ns/1ns
`include "deser_datapath_defines.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, rq;
   logic line_active_strobe = 0, aud_pkt_valid = 0, chk_valid = 0;
   logic [23:0] pix_in = 24'hABCDEF, aud_pkt_data = 24'h123456;
   logic [7:0] chk_byte = 8'h0;
   wire [31:0] hrdata;
   wire [23:0] pix_out_r;
   wire [6:0] fc_cfg_data;
   wire hreadyout, hresp, fc_cfg_valid, pix_valid_r, aud_on_pixel_pins_r;
   wire protection_enable, pixel_mode_18, audio_inband_sel;
   wire four_ch_audio_en, irq;
   wire hready = hreadyout;
   wire [3:0] dec = {protection_enable, pixel_mode_18, audio_inband_sel,
      four_ch_audio_en};
   int fails = 0, cmp_count = 0;
   localparam logic [11:0] A_CFG = {`IDX_DATAPATH_CFG, 2'b00};
   localparam logic [11:0] A_RX = {`IDX_RX_MODE, 2'b00};
   localparam logic [11:0] A_IST = {`IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] A_IMSK = {`IDX_IRQ_MASK, 2'b00};
   localparam logic [11:0] A_PROT = {`IDX_PROT_STATUS, 2'b00};
   logic [11:0] regs [6] = '{A_CFG, A_RX, A_IST, A_IMSK, A_PROT, 12'h0FC};
   logic [7:0] cfgs [5] = '{8'h0E, 8'h09, 8'h01, 8'h08, 8'h40};
   logic [3:0] decs [5] = '{4'hE, 4'h9, 4'h8, 4'h8, 4'h0};
   logic [9:0] pc [8] = '{10'h002, 10'h000, 10'h080, 10'h082, 10'h101,
      10'h003, 10'h043, 10'h012};
   logic [25:0] pe [8] = '{26'h2ABCDEF, 26'h0ABCDEF, 26'h2ABCDEF,
      26'h0ABCDEF, 26'h2ABCDEF, 26'h1123456, 26'h2ABCDEF, 26'h2A8CCEC};
   always #20 hclk = ~hclk;
   deser_datapath_config_regs dut_u (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
      .hresp, .fc_cfg_valid, .fc_cfg_data, .line_active_strobe, .pix_in,
      .aud_pkt_valid, .aud_pkt_data, .chk_valid, .chk_byte, .pix_out_r,
      .pix_valid_r, .aud_on_pixel_pins_r, .protection_enable,
      .pixel_mode_18, .audio_inband_sel, .four_ch_audio_en, .irq);
   fc_serializer_model fc_u (.hclk, .fc_cfg_valid, .fc_cfg_data);
   // ********************
   // Bus tasks
   // ********************
   // Ready and read data are taken at the rising edge, before it updates
   task wt;
      begin
         @(posedge hclk);
         while (hready !== 1'b1) @(posedge hclk);
         rq = hrdata;
      end
   endtask
   task bus(input logic [11:0] a, input logic w, input logic [7:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= w;
         wt();
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= {24'h0, d};
         wt();
      end
   endtask
   task rdck(input string n, input logic [11:0] a, input logic [7:0] e);
      begin
         bus(a, 1'b0, 8'h00);
         `CHK(n, {24'h0, e}, rq)
      end
   endtask
   task pix(input logic [9:0] c, input logic [25:0] e);
      begin
         bus(A_CFG, 1'b1, c[9:2]);
         line_active_strobe <= c[1];
         aud_pkt_valid <= c[0];
         @(posedge hclk);
         @(negedge hclk);
         `CHK("pix", e, {pix_valid_r, aud_on_pixel_pins_r, pix_out_r})
         @(posedge hclk);
      end
   endtask
   task line(input logic [7:0] b);
      begin
         pix_in <= 24'h010203;
         line_active_strobe <= 1'b1;
         repeat (2) @(posedge hclk);
         line_active_strobe <= 1'b0;
         chk_valid <= 1'b1;
         chk_byte <= b;
         @(posedge hclk);
         chk_valid <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask
   task end_of_test;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, fails);
         if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask
   // ********************
   // Sequence
   // ********************
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(12'h0FC, 1'b1, 8'hFF);
      foreach (regs[i]) rdck("reset", regs[i], 8'h00);
      foreach (cfgs[i]) begin
         bus(A_CFG, 1'b1, cfgs[i]);
         rdck("cfg", A_CFG, cfgs[i]);
         `CHK("decode", decs[i], dec)
      end
      bus(A_IMSK, 1'b1, 8'h07);
      bus(A_CFG, 1'b1, 8'h00);
      fc_u.send(7'h2A, 0);
      rdck("fc load", A_CFG, 8'h2A);
      rdck("fc applied", A_IST, 8'h02);
      `CHK("irq", 1'b1, irq)
      bus(A_IST, 1'b1, 8'h02);
      rdck("w1c", A_IST, 8'h00);
      `CHK("irq clr", 1'b0, irq)
      bus(A_CFG, 1'b1, 8'h80);
      fc_u.send(7'h7F, 2);
      rdck("lock", A_CFG, 8'h80);
      rdck("blocked", A_IST, 8'h04);
      `CHK("irq blk", 1'b1, irq)
      bus(A_IMSK, 1'b1, 8'h00);
      rdck("mask", A_IMSK, 8'h00);
      `CHK("irq mask", 1'b0, irq)
      foreach (pc[i]) pix(pc[i], pe[i]);
      line_active_strobe <= 1'b0;
      aud_pkt_valid <= 1'b0;
      bus(A_CFG, 1'b1, 8'h00);
      bus(A_RX, 1'b1, 8'h80);
      line(8'h0C);
      rdck("sum ok", A_PROT, 8'h00);
      line(8'h00);
      rdck("sum bad", A_PROT, 8'h11);
      rdck("sum irq", A_IST, 8'h05);
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge hclk);
      fails++;
      end_of_test();
   end
endmodule // tb_top
